// file: hdl/lu_bank_cfg.svh
// index map, reset values and address windows of the per-unit register bank
// assumes an 8-bit index space reached through an index/data port pair
`ifndef LU_BANK_CFG_SVH
`define LU_BANK_CFG_SVH

`define IDX_UNIT_NUM 8'h07
`define IDX_POWER_CTRL 8'h22
`define IDX_BANK_FIRST 8'h30
`define IDX_ENABLE 8'h30
`define IDX_IO_BASE_HI 8'h60
`define IDX_IO_BASE_LO 8'h61
`define IDX_SEC_BASE_HI 8'h62
`define IDX_SEC_BASE_LO 8'h63
`define IDX_IRQ_FIRST 8'h70
`define IDX_IRQ_SECOND 8'h72
`define IDX_DMA_CHOICE 8'h74

`define ENABLE_BIT 0
`define RST_BYTE 8'h00
`define RST_DMA 8'h04
`define RST_UNIT_NUM 8'h00
`define RST_IRQ_EDGE_HIGH 8'hff

`define LDN_FLOPPY 8'h00
`define LDN_PARALLEL 8'h03
`define LDN_SERIAL1 8'h04
`define LDN_SERIAL2 8'h05
`define LDN_RTC 8'h06
`define LDN_KEYBOARD 8'h07
`define LDN_AUX 8'h08
`define LDN_ACPI 8'h0a

`define PWR_BIT_FLOPPY 0
`define PWR_BIT_PARALLEL 3
`define PWR_BIT_SERIAL1 4
`define PWR_BIT_SERIAL2 5

`define BASE_MIN_STD 16'h0100
`define BASE_MAX_STD 16'h0ff8
`define BASE_MAX_PAR 16'h0ffc
`define BASE_MIN_ZERO 16'h0000
`define BASE_MAX_RTC 16'h0ffe
`define BASE_MAX_ACPI 16'h0fe7
`define ALIGN_STD 8
`define ALIGN_PAR 4
`define ALIGN_RTC 2
`define ALIGN_ACPI 24

`endif

// file: hdl/lu_bank_pkg.sv
// shared types of the per-unit configuration bank
// constants live in lu_bank_cfg.svh
package lu_bank_pkg;
    typedef logic [7:0] cfg_byte_t;
    typedef logic [15:0] io_addr_t;
    typedef logic [7:0] unit_mask_t;
endpackage

// file: hdl/unit_bank.sv
// one logical unit's register set: enable, base addresses, irq and dma selects
// assumes the parent decodes the unit number and drives one write at a time
`timescale 1ns/1ps
`default_nettype none
`include "lu_bank_cfg.svh"
module unit_bank
    import lu_bank_pkg::*;
#(
    parameter bit HAS_PRI = 1'b1,
    parameter bit HAS_SEC = 1'b0,
    parameter bit HAS_IRQ2 = 1'b0,
    parameter bit HAS_DMA = 1'b0,
    parameter bit HAS_PWR = 1'b0,
    parameter bit STBY_ENABLE = 1'b0,
    parameter io_addr_t PRI_MIN = `BASE_MIN_STD,
    parameter io_addr_t PRI_MAX = `BASE_MAX_STD,
    parameter int PRI_ALIGN = `ALIGN_STD,
    parameter io_addr_t SEC_MIN = `BASE_MIN_STD,
    parameter io_addr_t SEC_MAX = `BASE_MAX_STD,
    parameter int SEC_ALIGN = `ALIGN_STD
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mainClr,
    input wire logic regWr,
    input wire cfg_byte_t regIdx,
    input wire cfg_byte_t wrData,
    input wire logic pwrWr,
    input wire logic pwrVal,
    output cfg_byte_t rdData,
    output logic enableBit,
    output logic powerBit,
    output io_addr_t priBase,
    output io_addr_t secBase,
    output logic priOk,
    output logic secOk,
    output cfg_byte_t irqFirst,
    output cfg_byte_t irqSecond,
    output cfg_byte_t dmaChoice
);
    logic enable_q;
    logic power_q;
    cfg_byte_t priHi_q, priLo_q, secHi_q, secLo_q, irq1_q, irq2_q, dma_q;

    function automatic logic inWindow(io_addr_t a, io_addr_t lo, io_addr_t hi, int al);
        inWindow = (a >= lo) && (a <= hi) && ((32'(a) % al) == 0);
    endfunction

    // with HAS_PWR set, enable and power bit mirror each other on every write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enable_q <= 1'b0;
        end else if (mainClr && !STBY_ENABLE) begin
            enable_q <= 1'b0;
        end else if (regWr && regIdx == `IDX_ENABLE) begin
            enable_q <= wrData[`ENABLE_BIT];
        end else if (pwrWr && HAS_PWR) begin
            enable_q <= pwrVal;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            power_q <= 1'b0;
        end else if (mainClr) begin
            power_q <= 1'b0;
        end else if (HAS_PWR && pwrWr) begin
            power_q <= pwrVal;
        end else if (HAS_PWR && regWr && regIdx == `IDX_ENABLE) begin
            power_q <= wrData[`ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            priHi_q <= `RST_BYTE;
            priLo_q <= `RST_BYTE;
            secHi_q <= `RST_BYTE;
            secLo_q <= `RST_BYTE;
            irq1_q <= `RST_BYTE;
            irq2_q <= `RST_BYTE;
            dma_q <= `RST_DMA;
        end else if (mainClr) begin
            priHi_q <= `RST_BYTE;
            priLo_q <= `RST_BYTE;
            secHi_q <= `RST_BYTE;
            secLo_q <= `RST_BYTE;
            irq1_q <= `RST_BYTE;
            irq2_q <= `RST_BYTE;
            dma_q <= `RST_DMA;
        end else if (regWr) begin
            if (HAS_PRI && regIdx == `IDX_IO_BASE_HI) priHi_q <= wrData;
            if (HAS_PRI && regIdx == `IDX_IO_BASE_LO) priLo_q <= wrData;
            if (HAS_SEC && regIdx == `IDX_SEC_BASE_HI) secHi_q <= wrData;
            if (HAS_SEC && regIdx == `IDX_SEC_BASE_LO) secLo_q <= wrData;
            if (regIdx == `IDX_IRQ_FIRST) irq1_q <= wrData;
            if (HAS_IRQ2 && regIdx == `IDX_IRQ_SECOND) irq2_q <= wrData;
            if (HAS_DMA && regIdx == `IDX_DMA_CHOICE) dma_q <= wrData;
        end
    end

    // every index not listed reads zero and its writes fall through
    always_comb begin
        rdData = `RST_BYTE;
        unique case (regIdx)
            `IDX_ENABLE: rdData = {7'h00, enable_q};
            `IDX_IO_BASE_HI: rdData = HAS_PRI ? priHi_q : `RST_BYTE;
            `IDX_IO_BASE_LO: rdData = HAS_PRI ? priLo_q : `RST_BYTE;
            `IDX_SEC_BASE_HI: rdData = HAS_SEC ? secHi_q : `RST_BYTE;
            `IDX_SEC_BASE_LO: rdData = HAS_SEC ? secLo_q : `RST_BYTE;
            `IDX_IRQ_FIRST: rdData = irq1_q;
            `IDX_IRQ_SECOND: rdData = HAS_IRQ2 ? irq2_q : `RST_BYTE;
            `IDX_DMA_CHOICE: rdData = HAS_DMA ? dma_q : `RST_BYTE;
            default: rdData = `RST_BYTE;
        endcase
    end

    assign enableBit = enable_q;
    assign powerBit = HAS_PWR ? power_q : 1'b0;
    assign priBase = {priHi_q, priLo_q};
    assign secBase = {secHi_q, secLo_q};
    assign priOk = HAS_PRI && inWindow({priHi_q, priLo_q}, PRI_MIN, PRI_MAX, PRI_ALIGN);
    assign secOk = HAS_SEC && inWindow({secHi_q, secLo_q}, SEC_MIN, SEC_MAX, SEC_ALIGN);
    assign irqFirst = irq1_q;
    assign irqSecond = irq2_q;
    assign dmaChoice = dma_q;
endmodule
`default_nettype wire

// file: hdl/logical_unit_config_bank.sv
// per-unit configuration banks behind the index/data configuration port
// assumes cfgMode and the port strobes come from same-clock host decode logic;
// supply and host reset pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "lu_bank_cfg.svh"

// Function
// - index 0x30 bit0 enables selected unit
// - reserved 0x31-0x5f ignore writes, read zero
// - primary base from 0x60 high, 0x61 low
// - second base from 0x62 high, 0x63 low
// - unused base indexes ignore writes, read zero
// - base registers clear on either reset source
// - irq select 0x70 per unit, cleared by resets
// - 0x72 only in keyboard unit
// - routed interrupts default active-high edge
// - 0x71, 0x73, 0x76-0xdf ignore writes, read zero
// - dma select 0x74 in three units, resets 0x04
// - 0x75 never implemented
// - 0xe0-0xff reserved
// - unit on when enable or power bit set
// - enable and power bits mirror each write in floppy, parallel, serial1 and serial2
// - out-of-range base ignores host accesses
// - serial2 enable cleared by standby reset only
// - unit number at 0x07 selects shown bank
// - registers reachable only in configuration state
// - power control: bits 0,3,4,5 per unit
module logical_unit_config_bank
    import lu_bank_pkg::*;
#(
    parameter int UNITS = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mainPorN,
    input wire logic hostResetDrv,
    input wire logic cfgMode,
    input wire logic idxWr,
    input wire logic dataWr,
    input wire logic dataRd,
    input wire cfg_byte_t busData,
    output cfg_byte_t rdData,
    output logic rdValid,
    input wire io_addr_t ioAddr,
    input wire logic ioValid,
    output unit_mask_t unitActive,
    output unit_mask_t unitHit,
    output unit_mask_t priBaseOk,
    output unit_mask_t secBaseOk,
    output logic [8*UNITS-1:0] irqFirst,
    output logic [8*UNITS-1:0] irqSecond,
    output logic [8*UNITS-1:0] dmaChoice,
    output logic [16*UNITS-1:0] priBase,
    output logic [16*UNITS-1:0] secBase,
    output unit_mask_t irqEdgeHigh
);
    // unit table, one column per bank
    localparam cfg_byte_t LDN_TAB [8] = '{`LDN_FLOPPY, `LDN_PARALLEL, `LDN_SERIAL1,
        `LDN_SERIAL2, `LDN_RTC, `LDN_KEYBOARD, `LDN_AUX, `LDN_ACPI};
    localparam logic [7:0] HAS_PRI_TAB = 8'h8f;
    localparam logic [7:0] HAS_SEC_TAB = 8'h18;
    localparam logic [7:0] HAS_IRQ2_TAB = 8'h20;
    localparam logic [7:0] HAS_DMA_TAB = 8'h0b;
    localparam logic [7:0] HAS_PWR_TAB = 8'h0f;
    localparam logic [7:0] STBY_TAB = 8'h08;
    localparam int PWR_POS_TAB [8] = '{`PWR_BIT_FLOPPY, `PWR_BIT_PARALLEL,
        `PWR_BIT_SERIAL1, `PWR_BIT_SERIAL2, 0, 0, 0, 0};
    localparam io_addr_t PRI_MIN_TAB [8] = '{`BASE_MIN_STD, `BASE_MIN_STD,
        `BASE_MIN_STD, `BASE_MIN_STD, `BASE_MIN_STD, `BASE_MIN_STD,
        `BASE_MIN_STD, `BASE_MIN_ZERO};
    localparam io_addr_t PRI_MAX_TAB [8] = '{`BASE_MAX_STD, `BASE_MAX_PAR,
        `BASE_MAX_STD, `BASE_MAX_STD, `BASE_MAX_STD, `BASE_MAX_STD,
        `BASE_MAX_STD, `BASE_MAX_ACPI};
    localparam int PRI_ALIGN_TAB [8] = '{`ALIGN_STD, `ALIGN_PAR, `ALIGN_STD,
        `ALIGN_STD, `ALIGN_STD, `ALIGN_STD, `ALIGN_STD, `ALIGN_ACPI};
    localparam io_addr_t SEC_MIN_TAB [8] = '{`BASE_MIN_STD, `BASE_MIN_STD,
        `BASE_MIN_STD, `BASE_MIN_STD, `BASE_MIN_ZERO, `BASE_MIN_STD,
        `BASE_MIN_STD, `BASE_MIN_STD};
    localparam io_addr_t SEC_MAX_TAB [8] = '{`BASE_MAX_STD, `BASE_MAX_STD,
        `BASE_MAX_STD, `BASE_MAX_STD, `BASE_MAX_RTC, `BASE_MAX_STD,
        `BASE_MAX_STD, `BASE_MAX_STD};
    localparam int SEC_ALIGN_TAB [8] = '{`ALIGN_STD, `ALIGN_STD, `ALIGN_STD,
        `ALIGN_STD, `ALIGN_RTC, `ALIGN_STD, `ALIGN_STD, `ALIGN_STD};

    // pin synchronisers, three stages
    logic [2:0] porSync_q;
    logic [2:0] drvSync_q;
    logic porLow_q;
    logic drvHigh_q;
    logic mainClr_q;

    cfg_byte_t index_q;
    cfg_byte_t unitNum_q;
    cfg_byte_t rdData_q;
    logic rdValid_q;
    unit_mask_t active_q;
    unit_mask_t hit_q;
    unit_mask_t priOk_q;
    unit_mask_t secOk_q;
    unit_mask_t edgeHigh_q;

    unit_mask_t bankSel;
    unit_mask_t bankWr;
    unit_mask_t enableBits;
    unit_mask_t powerBits;
    unit_mask_t priOkRaw;
    unit_mask_t secOkRaw;
    unit_mask_t hitRaw;
    cfg_byte_t bankRd [UNITS];
    cfg_byte_t powerByte;
    cfg_byte_t bankMux;
    cfg_byte_t readNext;
    logic pwrWr;
    logic portWr;
    logic portRd;

    // reset pins flop to asserted so the banks hold cleared until release settles
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            porSync_q <= 3'h0;
            drvSync_q <= 3'h7;
        end else begin
            porSync_q <= {porSync_q[1:0], mainPorN};
            drvSync_q <= {drvSync_q[1:0], hostResetDrv};
        end
    end

    // a level counts only once stages two and three agree
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            porLow_q <= 1'b1;
            drvHigh_q <= 1'b1;
        end else begin
            if (porSync_q[1] == porSync_q[2]) porLow_q <= !porSync_q[2];
            if (drvSync_q[1] == drvSync_q[2]) drvHigh_q <= drvSync_q[2];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mainClr_q <= 1'b1;
        end else begin
            mainClr_q <= porLow_q || drvHigh_q;
        end
    end

    // port strobes only count inside the configuration state
    assign portWr = cfgMode && dataWr && !mainClr_q;
    assign portRd = cfgMode && dataRd;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            index_q <= `RST_BYTE;
        end else if (mainClr_q) begin
            index_q <= `RST_BYTE;
        end else if (cfgMode && idxWr) begin
            index_q <= busData;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            unitNum_q <= `RST_UNIT_NUM;
        end else if (mainClr_q) begin
            unitNum_q <= `RST_UNIT_NUM;
        end else if (portWr && index_q == `IDX_UNIT_NUM) begin
            unitNum_q <= busData;
        end
    end

    assign pwrWr = portWr && index_q == `IDX_POWER_CTRL;

    genvar u;
    generate
        for (u = 0; u < UNITS; u++) begin : g_unit
            assign bankSel[u] = unitNum_q == LDN_TAB[u];
            assign bankWr[u] = portWr && bankSel[u] && index_q >= `IDX_BANK_FIRST;

            unit_bank #(
                .HAS_PRI(HAS_PRI_TAB[u]),
                .HAS_SEC(HAS_SEC_TAB[u]),
                .HAS_IRQ2(HAS_IRQ2_TAB[u]),
                .HAS_DMA(HAS_DMA_TAB[u]),
                .HAS_PWR(HAS_PWR_TAB[u]),
                .STBY_ENABLE(STBY_TAB[u]),
                .PRI_MIN(PRI_MIN_TAB[u]),
                .PRI_MAX(PRI_MAX_TAB[u]),
                .PRI_ALIGN(PRI_ALIGN_TAB[u]),
                .SEC_MIN(SEC_MIN_TAB[u]),
                .SEC_MAX(SEC_MAX_TAB[u]),
                .SEC_ALIGN(SEC_ALIGN_TAB[u])
            ) u_bank (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .mainClr(mainClr_q),
                .regWr(bankWr[u]),
                .regIdx(index_q),
                .wrData(busData),
                .pwrWr(pwrWr),
                .pwrVal(busData[PWR_POS_TAB[u]]),
                .rdData(bankRd[u]),
                .enableBit(enableBits[u]),
                .powerBit(powerBits[u]),
                .priBase(priBase[16*u +: 16]),
                .secBase(secBase[16*u +: 16]),
                .priOk(priOkRaw[u]),
                .secOk(secOkRaw[u]),
                .irqFirst(irqFirst[8*u +: 8]),
                .irqSecond(irqSecond[8*u +: 8]),
                .dmaChoice(dmaChoice[8*u +: 8])
            );

            // fixed window of one alignment unit above the base
            assign hitRaw[u] = ioValid && active_q[u] && (
                (priOkRaw[u] && ioAddr >= priBase[16*u +: 16]
                    && 32'(ioAddr) < 32'(priBase[16*u +: 16]) + PRI_ALIGN_TAB[u])
                || (secOkRaw[u] && ioAddr >= secBase[16*u +: 16]
                    && 32'(ioAddr) < 32'(secBase[16*u +: 16]) + SEC_ALIGN_TAB[u]));
        end
    endgenerate

    // power byte gathers the mirrored bits at their fixed positions
    always_comb begin
        powerByte = `RST_BYTE;
        for (int i = 0; i < UNITS; i++) begin
            if (HAS_PWR_TAB[i]) powerByte[PWR_POS_TAB[i]] = powerBits[i];
        end
    end

    // unknown unit numbers select no bank and read zero
    always_comb begin
        bankMux = `RST_BYTE;
        for (int i = 0; i < UNITS; i++) begin
            if (bankSel[i]) bankMux = bankMux | bankRd[i];
        end
    end

    always_comb begin
        readNext = `RST_BYTE;
        if (index_q == `IDX_UNIT_NUM) begin
            readNext = unitNum_q;
        end else if (index_q == `IDX_POWER_CTRL) begin
            readNext = powerByte;
        end else if (index_q >= `IDX_BANK_FIRST) begin
            readNext = bankMux;
        end
    end

    // read data is taken from state before any same-cycle write lands
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdData_q <= `RST_BYTE;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= portRd;
            if (portRd) rdData_q <= readNext;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            active_q <= '0;
        end else begin
            active_q <= enableBits | powerBits;
        end
    end

    // accesses outside a unit's legal window never produce a hit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            priOk_q <= '0;
            secOk_q <= '0;
            hit_q <= '0;
        end else begin
            priOk_q <= priOkRaw;
            secOk_q <= secOkRaw;
            hit_q <= hitRaw;
        end
    end

    // no polarity control here, every routed line stays edge high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            edgeHigh_q <= `RST_IRQ_EDGE_HIGH;
        end else begin
            edgeHigh_q <= `RST_IRQ_EDGE_HIGH;
        end
    end

    assign rdData = rdData_q;
    assign rdValid = rdValid_q;
    assign unitActive = active_q;
    assign unitHit = hit_q;
    assign priBaseOk = priOk_q;
    assign secBaseOk = secOk_q;
    assign irqEdgeHigh = edgeHigh_q;
endmodule
`default_nettype wire

// file: tb/cfg_host.sv
// host side of the index/data configuration port
// assumes the bank samples strobes on the rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module cfg_host
    import lu_bank_pkg::*;
(
    input wire logic clk_sys,
    output logic idxWr,
    output logic dataWr,
    output logic dataRd,
    output cfg_byte_t busData,
    input wire cfg_byte_t rdData,
    input wire logic rdValid
);
    initial begin
        {idxWr, dataWr, dataRd} = 3'b000;
        busData = 8'h5a;
    end
    // idle bus shows inverted data so a stale byte is never mistaken for fresh
    task automatic put(input logic [1:0] kind, input cfg_byte_t val);
        @(negedge clk_sys);
        busData = val;
        idxWr = kind == 2'd0;
        dataWr = kind == 2'd1;
        dataRd = kind == 2'd2;
        @(negedge clk_sys);
        {idxWr, dataWr, dataRd} = 3'b000;
        busData = ~val;
    endtask
    task automatic wr(input cfg_byte_t idx, input cfg_byte_t val);
        put(2'd0, idx);
        put(2'd1, val);
    endtask
    task automatic rd(input cfg_byte_t idx, output cfg_byte_t val, output logic ok);
        put(2'd0, idx);
        put(2'd2, 8'h00);
        ok = rdValid;
        val = rdData;
    endtask
endmodule
`default_nettype wire

// file: tb/lu_bank_checker_properties.sv
// port-level checks of the per-unit configuration bank
// assumes only the top module's ports; tracks index and unit itself
`timescale 1ns/1ps
`default_nettype none
module lu_bank_checker
    import lu_bank_pkg::*;
#(
    parameter int UNITS = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mainPorN,
    input wire logic hostResetDrv,
    input wire logic cfgMode,
    input wire logic idxWr,
    input wire logic dataWr,
    input wire logic dataRd,
    input wire cfg_byte_t busData,
    input wire cfg_byte_t rdData,
    input wire logic rdValid,
    input wire logic ioValid,
    input wire unit_mask_t unitActive,
    input wire unit_mask_t unitHit,
    input wire unit_mask_t priBaseOk,
    input wire unit_mask_t secBaseOk,
    input wire logic [8*UNITS-1:0] irqFirst,
    input wire logic [8*UNITS-1:0] irqSecond,
    input wire logic [8*UNITS-1:0] dmaChoice,
    input wire logic [16*UNITS-1:0] priBase,
    input wire logic [16*UNITS-1:0] secBase,
    input wire unit_mask_t irqEdgeHigh
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    localparam logic [8*UNITS-1:0] KBD_MASK = (8*UNITS)'(64'hff << 40);
    localparam logic [16*UNITS-1:0] SEC_MASK = (16*UNITS)'(128'hffff_ffff << 48);
    cfg_byte_t idxQ;
    cfg_byte_t unitQ;
    logic [2:0] quietCnt;
    logic quiet;
    logic resv;
    int selSlot;
    // pin clears pass a synchroniser, so settle margin before trusting writes
    assign quiet = quietCnt == 3'd7;
    assign resv = (idxQ >= 8'h31 && idxQ <= 8'h5f) || idxQ == 8'h71 || idxQ == 8'h73
        || (idxQ >= 8'h75 && idxQ <= 8'hdf);
    assign selSlot = unitQ == 8'h00 ? 0 : unitQ == 8'h0a ? 7
        : (unitQ >= 8'h03 && unitQ <= 8'h08) ? int'(unitQ) - 2 : 8;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn || !mainPorN || hostResetDrv) begin
            quietCnt <= 3'd0;
        end else if (!quiet) begin
            quietCnt <= quietCnt + 3'd1;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn || !quiet) begin
            idxQ <= 8'h00;
            unitQ <= 8'h00;
        end else if (cfgMode && idxWr) begin
            idxQ <= busData;
        end else if (cfgMode && dataWr && idxQ == 8'h07) begin
            unitQ <= busData;
        end
    end
    a_read_answered: assert property (
        cfgMode && dataRd |=> rdValid) else $error("read not answered");
    a_no_stray_valid: assert property (
        !(cfgMode && dataRd) |=> !rdValid) else $error("stray read valid");
    a_reserved_reads_zero: assert property (
        cfgMode && dataRd && quiet && resv |=> rdData == 8'h00) else $error("reserved nonzero");
    a_irq_write_lands: assert property (
        cfgMode && dataWr && quiet && idxQ == 8'h70 && selSlot < 8
        |=> irqFirst[8*selSlot +: 8] == $past(busData)) else $error("irq write lost");
    a_enable_sets_active: assert property (
        cfgMode && dataWr && quiet && idxQ == 8'h30 && selSlot < 8
        |-> ##2 unitActive[selSlot] == $past(busData[0], 2)) else $error("active wrong");
    a_pin_clear_values: assert property (
        (!mainPorN || hostResetDrv)[*6] |=> priBase == '0 && secBase == '0
        && irqFirst == '0 && dmaChoice == {UNITS{8'h04}}) else $error("clear values");
    a_hit_needs_cause: assert property (
        |unitHit |-> $past(ioValid)
        && (unitHit & ~($past(unitActive) & ($past(priBaseOk) | $past(secBaseOk)))) == '0)
        else $error("unexpected hit");
    a_cfg_off_ignored: assert property (
        !cfgMode && dataWr && quiet |=> $stable(irqFirst) && $stable(priBase)
        && $stable(unitActive)) else $error("write taken outside config");
    a_second_irq_kbd: assert property (
        (irqSecond & ~KBD_MASK) == '0) else $error("second irq outside keyboard");
    a_second_base_used: assert property (
        (secBase & ~SEC_MASK) == '0) else $error("unused second base set");
    a_edge_high_irq: assert property (
        irqEdgeHigh == 8'hff) else $error("irq polarity wrong");
endmodule
bind logical_unit_config_bank lu_bank_checker #(.UNITS(UNITS)) lu_bank_checker_inst (
    .clk_sys(clk_sys), .resetn(resetn), .mainPorN(mainPorN), .hostResetDrv(hostResetDrv),
    .cfgMode(cfgMode), .idxWr(idxWr), .dataWr(dataWr), .dataRd(dataRd),
    .busData(busData), .rdData(rdData), .rdValid(rdValid), .ioValid(ioValid),
    .unitActive(unitActive), .unitHit(unitHit), .priBaseOk(priBaseOk),
    .secBaseOk(secBaseOk), .irqFirst(irqFirst), .irqSecond(irqSecond),
    .dmaChoice(dmaChoice), .priBase(priBase), .secBase(secBase), .irqEdgeHigh(irqEdgeHigh));
`default_nettype wire

// file: tb/logical_unit_config_bank_tb.sv
// self-checking bench for the per-unit configuration bank
// assumes cfg_host drives the port; bench drives pins and the io probe
`timescale 1ns/1ps
`default_nettype none
module logical_unit_config_bank_tb;
    import lu_bank_pkg::*;
    localparam cfg_byte_t NUM [8] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a};
    localparam logic [3:0] FEAT [8] = '{4'h9, 4'h9, 4'h8, 4'hd, 4'h4, 4'h2, 4'h0, 4'h8};
    localparam cfg_byte_t IDX [7] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h72, 8'h74};
    localparam cfg_byte_t RSV [18] = '{8'h31, 8'h37, 8'h38, 8'h3f, 8'h40, 8'h5f, 8'h64,
        8'h6f, 8'h71, 8'h73, 8'h75, 8'h76, 8'ha8, 8'ha9, 8'hdf, 8'he0, 8'hfe, 8'hff};
    logic clk_sys, resetn, mainPorN, hostResetDrv, cfgMode, ioValid, on, ok;
    logic idxWr, dataWr, dataRd, rdValid;
    cfg_byte_t busData, rdData, v, pat;
    io_addr_t ioAddr;
    unit_mask_t unitActive, unitHit, priBaseOk, secBaseOk, irqEdgeHigh;
    logic [63:0] irqFirst, irqSecond, dmaChoice;
    logic [127:0] priBase, secBase;
    int s, k, bad_count, samples_checked;
    logical_unit_config_bank #(.UNITS(8)) logical_unit_config_bank_inst (
        .clk_sys(clk_sys), .resetn(resetn), .mainPorN(mainPorN),
        .hostResetDrv(hostResetDrv), .cfgMode(cfgMode), .idxWr(idxWr), .dataWr(dataWr),
        .dataRd(dataRd), .busData(busData), .rdData(rdData), .rdValid(rdValid),
        .ioAddr(ioAddr), .ioValid(ioValid), .unitActive(unitActive), .unitHit(unitHit),
        .priBaseOk(priBaseOk), .secBaseOk(secBaseOk), .irqFirst(irqFirst),
        .irqSecond(irqSecond), .dmaChoice(dmaChoice), .priBase(priBase),
        .secBase(secBase), .irqEdgeHigh(irqEdgeHigh));
    cfg_host cfg_host_inst (.clk_sys(clk_sys), .idxWr(idxWr), .dataWr(dataWr),
        .dataRd(dataRd), .busData(busData), .rdData(rdData), .rdValid(rdValid));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // valid flag folded in so one compare covers data and strobe
    task automatic rdc(input string n, input cfg_byte_t idx, input cfg_byte_t exp);
        cfg_host_inst.rd(idx, v, ok);
        check(n, {7'h00, ok, v}, {8'h01, exp});
    endtask
    task automatic pinClear(input logic which);
        mainPorN = which;
        hostResetDrv = which;
        cyc(8);
        mainPorN = 1'b1;
        hostResetDrv = 1'b0;
        cyc(8);
        check("unitActive", unitActive, 8'h08);
        check("cleared", 16'(|{priBase, secBase, irqFirst}), 16'h0);
        check("dmaChoice", 16'(dmaChoice === {8{8'h04}}), 16'h1);
    endtask
    task automatic probe(input io_addr_t a, input unit_mask_t exp);
        cyc(2);
        ioAddr = a;
        ioValid = 1'b1;
        cyc(1);
        ioValid = 1'b0;
        check("unitHit", unitHit, exp);
    endtask
    initial begin
        resetn = 1'b0;
        mainPorN = 1'b1;
        hostResetDrv = 1'b0;
        cfgMode = 1'b1;
        ioValid = 1'b0;
        ioAddr = 16'h0000;
        bad_count = 0;
        samples_checked = 0;
        cyc(4);
        resetn = 1'b1;
        cyc(8);
        check("irqEdgeHigh", irqEdgeHigh, 8'hff);
        for (s = 0; s < 8; s++) begin
            cfg_host_inst.wr(8'h07, NUM[s]);
            for (k = 0; k < 7; k++) begin
                on = k < 2 ? FEAT[s][3] : k < 4 ? FEAT[s][2] : k == 4 ? 1'b1
                    : k == 5 ? FEAT[s][1] : FEAT[s][0];
                pat = {s[3:0], k[3:0]} ^ 8'h80;
                rdc("reset", IDX[k], (k == 6 && on) ? 8'h04 : 8'h00);
                cfg_host_inst.wr(IDX[k], pat);
                rdc("readback", IDX[k], on ? pat : 8'h00);
            end
            cfg_host_inst.wr(8'h30, 8'hff);
            rdc("enable", 8'h30, 8'h01);
            check("active", 16'(unitActive[s]), 16'h1);
            if (FEAT[s][3]) begin
                check("priBase", priBase[16*s +: 16], 16'h8081 ^ 16'(s * 'h1010));
            end
        end
        rdc("power", 8'h22, 8'h39);
        for (k = 0; k < 18; k++) begin
            cfg_host_inst.wr(RSV[k], 8'ha5);
            rdc("reserved", RSV[k], 8'h00);
        end
        pinClear(1'b0);
        pinClear(1'b1);
        cfg_host_inst.wr(8'h22, 8'h08);
        cyc(2);
        check("active", unitActive, 8'h02);
        cfg_host_inst.wr(8'h07, 8'h03);
        rdc("enable", 8'h30, 8'h01);
        cfg_host_inst.wr(8'h07, 8'h04);
        cfg_host_inst.wr(8'h60, 8'h03);
        cfg_host_inst.wr(8'h61, 8'hf8);
        cfg_host_inst.wr(8'h30, 8'h01);
        probe(16'h03fa, 8'h04);
        cfg_host_inst.wr(8'h61, 8'hf9);
        cyc(2);
        check("priBaseOk", 16'(priBaseOk[2]), 16'h0);
        probe(16'h03f9, 8'h00);
        cfgMode = 1'b0;
        cfg_host_inst.wr(8'h61, 8'hf8);
        cfgMode = 1'b1;
        rdc("cfgOff", 8'h61, 8'hf9);
        cfg_host_inst.wr(8'h61, 8'hf8);
        cfg_host_inst.wr(8'h30, 8'h00);
        probe(16'h03fa, 8'h00);
        cfg_host_inst.wr(8'h07, 8'h05);
        cfg_host_inst.wr(8'h30, 8'h01);
        resetn = 1'b0;
        cyc(2);
        check("active", unitActive, 8'h00);
        resetn = 1'b1;
        cyc(8);
        results();
    end
    // run is about a thousand cycles
    initial begin
        cyc(20000);
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
